// File: verilog/perc_pkg.sv
package perc_pkg;
    // Management register addresses
    localparam logic [4:0]  PERC_ADDR_RXCTL     = 5'h10;
    localparam logic [4:0]  PERC_ADDR_EVENT     = 5'h11;
    // Receive control field positions
    localparam int          PERC_RXC_GATE_BIT   = 0;
    localparam int          PERC_RXC_BYPASS_BIT = 1;
    localparam int          PERC_RXC_POL_BIT    = 4;
    localparam int          PERC_RXC_APOLD_BIT  = 5;
    // Event register layout
    localparam int          PERC_EVT_COUNT      = 8;
    localparam int          PERC_EVT_EN_LSB     = 8;
    localparam int          PERC_EV_NEG_DONE    = 0;
    localparam int          PERC_EV_REM_FAULT   = 1;
    localparam int          PERC_EV_LINK_DROP   = 2;
    localparam int          PERC_EV_PART_ACK    = 3;
    localparam int          PERC_EV_PAR_FAULT   = 4;
    localparam int          PERC_EV_PAGE_RX     = 5;
    localparam int          PERC_EV_RX_ERROR    = 6;
    localparam int          PERC_EV_JABBER      = 7;
    // Reset values
    localparam logic [15:0] PERC_EVENT_RESET    = 16'h0000;
    localparam logic [7:0]  PERC_FLAG_RESET     = 8'h00;
    localparam logic [7:0]  PERC_EN_RESET       = 8'h00;
    localparam logic [15:0] PERC_RXCTL_RESET    = 16'h0000;
    localparam logic [15:0] PERC_ZERO16         = 16'h0000;
endpackage : perc_pkg

// File: verilog/perc_event_flags.sv
// Sticky event flags, cleared by a read; an event in the clearing cycle survives.
module perc_event_flags
    import perc_pkg::*;
#(
    parameter int N = PERC_EVT_COUNT
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    // Events and clear
    input  wire logic [N-1:0] event_i,
    input  wire logic         clear_i,
    // Flags
    output logic      [N-1:0] flag_o
);
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_flag
            always_ff @(posedge clk_i) begin
                if (!resetn_i) begin
                    flag_o[g] <= 1'b0;
                end else if (event_i[g]) begin
                    flag_o[g] <= 1'b1;
                end else if (clear_i) begin
                    flag_o[g] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule : perc_event_flags

// File: verilog/perc_phy_event_ctrl.sv
// Summary of operation
// - Auto-polarity disable bit 5 set stops automatic receive polarity correction.
// - With auto-polarity on, polarity bit 4 is read-only and shows automatic inversion.
// - With auto-polarity off, polarity bit 4 is writable and forces inversion.
// - Bypass bit 1 in 100BASE-TX routes data around coding and scrambling.
// - Clock gating bit 0 in 100BASE-TX stops receive clock when idle.
// - Loopback disables clock gating; host avoids gating together with bypass.
// - Event register sits at address 0x11 and resets to 0x0000.
// - Status bits 0 to 7 stick until register read; read clears them.
// - Enable bits 8 to 15 let status bit eight lower raise interrupt.
// - Event register is readable over the management path for polling.
// - Jabber sets status bit 7; enable bit 15 gates it.
// - Receive error sets status bit 6; enable bit 14 gates it.
// - New page received sets status bit 5; enable bit 13 gates it.
// - Parallel detection fault sets status bit 4; enable bit 12 gates it.
// - Partner acknowledge burst sets status bit 3; enable bit 11 gates it.
// - Link OK to FAIL only sets status bit 2; enable bit 10 gates it.
// - Remote fault sets status bit 1; enable bit 9 gates it.
// - Negotiation complete sets status bit 0; enable bit 8 gates it.
// - Enable bits are plain read/write storage, reset zero, unaffected by reads.
module perc_phy_event_ctrl
    import perc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // Management register port
    input  wire logic [4:0]  mgmt_addr_i,
    input  wire logic        mgmt_wr_i,
    input  wire logic        mgmt_rd_i,
    input  wire logic [15:0] mgmt_wdata_i,
    output logic      [15:0] mgmt_rdata_o,
    output logic             mgmt_rvalid_o,
    // PHY status inputs
    input  wire logic        mode_100tx_i,
    input  wire logic        autoneg_en_i,
    input  wire logic        loopback_select_i,
    input  wire logic        rx_active_i,
    input  wire logic        polarity_wrong_i,
    input  wire logic        rx_data_i,
    input  wire logic        link_ok_i,
    // Event inputs, one-cycle pulses
    input  wire logic        jabber_i,
    input  wire logic        rx_error_i,
    input  wire logic        page_rx_i,
    input  wire logic        parallel_fault_i,
    input  wire logic        partner_ack_i,
    input  wire logic        remote_fault_i,
    input  wire logic        negotiation_done_i,
    // Receive path controls
    output logic             rx_data_o,
    output logic             rx_polarity_inverted_o,
    output logic             coding_sublayer_bypass_o,
    output logic             rx_clock_enable_o,
    // Interrupt toward mac_raw_irq_status
    output logic             phy_irq_o
);
    logic                      auto_polarity_disable_q;
    logic                      receive_polarity_invert_q;
    logic                      coding_sublayer_bypass_q;
    logic                      receive_clock_gating_q;
    logic                      auto_invert_q;
    logic                      link_ok_q;
    logic [PERC_EVT_COUNT-1:0] event_en_q;
    logic [PERC_EVT_COUNT-1:0] event_flag;
    logic [PERC_EVT_COUNT-1:0] event_in;
    logic                      link_drop;
    logic                      read_event;
    logic                      invert_now;
    logic [15:0]               rxctl_view;
    logic [15:0]               rdata_d;

    wire wr_rxctl = mgmt_wr_i && (mgmt_addr_i == PERC_ADDR_RXCTL);
    wire wr_event = mgmt_wr_i && (mgmt_addr_i == PERC_ADDR_EVENT);
    assign read_event = mgmt_rd_i && (mgmt_addr_i == PERC_ADDR_EVENT);

    // Receive control storage, one field per process
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            auto_polarity_disable_q <= 1'b0;
        end else if (wr_rxctl) begin
            auto_polarity_disable_q <= mgmt_wdata_i[PERC_RXC_APOLD_BIT];
        end
    end

    // Polarity is only software-owned once auto-polarity is off
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            receive_polarity_invert_q <= 1'b0;
        end else if (wr_rxctl && (auto_polarity_disable_q
                                  || mgmt_wdata_i[PERC_RXC_APOLD_BIT])) begin
            receive_polarity_invert_q <= mgmt_wdata_i[PERC_RXC_POL_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            coding_sublayer_bypass_q <= 1'b0;
        end else if (wr_rxctl) begin
            coding_sublayer_bypass_q <= mgmt_wdata_i[PERC_RXC_BYPASS_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            receive_clock_gating_q <= 1'b0;
        end else if (wr_rxctl) begin
            receive_clock_gating_q <= mgmt_wdata_i[PERC_RXC_GATE_BIT];
        end
    end

    // Automatic polarity tracker: latched during 10BASE-T negotiation
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            auto_invert_q <= 1'b0;
        end else if (auto_polarity_disable_q) begin
            auto_invert_q <= 1'b0;
        end else if (autoneg_en_i && !mode_100tx_i) begin
            auto_invert_q <= polarity_wrong_i;
        end
    end

    always_comb begin
        invert_now = auto_polarity_disable_q ? receive_polarity_invert_q
                                             : auto_invert_q;
    end

    // Receive path outputs, each registered on its own
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rx_data_o <= 1'b0;
        end else begin
            rx_data_o <= rx_data_i ^ invert_now;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rx_polarity_inverted_o <= 1'b0;
        end else begin
            rx_polarity_inverted_o <= invert_now;
        end
    end

    // Bypass only meaningful in 100BASE-TX; host keeps negotiation off
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            coding_sublayer_bypass_o <= 1'b0;
        end else begin
            coding_sublayer_bypass_o <= coding_sublayer_bypass_q && mode_100tx_i;
        end
    end

    // Loopback overrides gating so looped data always has a clock
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rx_clock_enable_o <= 1'b1;
        end else begin
            rx_clock_enable_o <= !(receive_clock_gating_q && mode_100tx_i
                                   && !loopback_select_i && !rx_active_i);
        end
    end

    // Link OK to FAIL edge only
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            link_ok_q <= 1'b0;
        end else begin
            link_ok_q <= link_ok_i;
        end
    end
    assign link_drop = link_ok_q && !link_ok_i;

    always_comb begin
        event_in                    = PERC_FLAG_RESET;
        event_in[PERC_EV_JABBER]    = jabber_i;
        event_in[PERC_EV_RX_ERROR]  = rx_error_i;
        event_in[PERC_EV_PAGE_RX]   = page_rx_i;
        event_in[PERC_EV_PAR_FAULT] = parallel_fault_i;
        event_in[PERC_EV_PART_ACK]  = partner_ack_i;
        event_in[PERC_EV_LINK_DROP] = link_drop;
        event_in[PERC_EV_REM_FAULT] = remote_fault_i;
        event_in[PERC_EV_NEG_DONE]  = negotiation_done_i;
    end

    perc_event_flags #(
        .N        (PERC_EVT_COUNT)
    ) u_flags (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .event_i  (event_in),
        .clear_i  (read_event),
        .flag_o   (event_flag)
    );

    // Enables: plain storage, reads leave them alone
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            event_en_q <= PERC_EN_RESET;
        end else if (wr_event) begin
            event_en_q <= mgmt_wdata_i[15:PERC_EVT_EN_LSB];
        end
    end

    // Interrupt holds while any enabled flag stays set
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            phy_irq_o <= 1'b0;
        end else begin
            phy_irq_o <= |(event_flag & event_en_q);
        end
    end

    always_comb begin
        rxctl_view                     = PERC_RXCTL_RESET;
        rxctl_view[PERC_RXC_APOLD_BIT] = auto_polarity_disable_q;
        rxctl_view[PERC_RXC_POL_BIT]   = invert_now;
        rxctl_view[PERC_RXC_BYPASS_BIT] = coding_sublayer_bypass_q;
        rxctl_view[PERC_RXC_GATE_BIT]  = receive_clock_gating_q;
    end

    always_comb begin
        rdata_d = PERC_ZERO16;
        if (mgmt_addr_i == PERC_ADDR_EVENT) begin
            rdata_d = {event_en_q, event_flag};
        end else if (mgmt_addr_i == PERC_ADDR_RXCTL) begin
            rdata_d = rxctl_view;
        end
    end

    // Read data captured with pre-clear flags, held until the next read
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            mgmt_rdata_o <= PERC_EVENT_RESET;
        end else if (mgmt_rd_i) begin
            mgmt_rdata_o <= rdata_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            mgmt_rvalid_o <= 1'b0;
        end else begin
            mgmt_rvalid_o <= mgmt_rd_i;
        end
    end
endmodule : perc_phy_event_ctrl

// File: bench/perc_phy_event_ctrl_asserts.sv
module perc_phy_event_ctrl_asserts
    import perc_pkg::*;
(
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        resetn_i,
    // Management port
    input wire logic        mgmt_wr_i,
    input wire logic        mgmt_rd_i,
    input wire logic [15:0] mgmt_rdata_o,
    input wire logic        mgmt_rvalid_o,
    // Status, events and outputs
    input wire logic        mode_100tx_i,
    input wire logic        loopback_select_i,
    input wire logic        rx_active_i,
    input wire logic        link_ok_i,
    input wire logic [6:0]  ev_i,
    input wire logic        coding_sublayer_bypass_o,
    input wire logic        rx_clock_enable_o,
    input wire logic        phy_irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_read;
        mgmt_rd_i ##1 mgmt_rvalid_o;
    endsequence
    sequence s_cause;
        $past(|ev_i, 2) || $past(mgmt_wr_i, 2) || ($past(link_ok_i, 3) && !$past(link_ok_i, 2));
    endsequence
    a_read_answer: assert property (mgmt_rd_i |-> s_read)
        else $error("read not answered");
    a_answer_cause: assert property (mgmt_rvalid_o |-> $past(mgmt_rd_i))
        else $error("answer without read");
    a_rdata_hold: assert property (!mgmt_rvalid_o |-> $stable(mgmt_rdata_o))
        else $error("read data moved");
    a_gate_cause: assert property (!rx_clock_enable_o |->
        $past(mode_100tx_i && !loopback_select_i && !rx_active_i)) else $error("bad gating");
    a_gate_loop: assert property (loopback_select_i |=> rx_clock_enable_o)
        else $error("gated in loopback");
    a_bypass_mode: assert property (coding_sublayer_bypass_o |-> $past(mode_100tx_i))
        else $error("bypass outside 100tx");
    a_irq_rise: assert property ($rose(phy_irq_o) |-> s_cause)
        else $error("irq without cause");
    a_irq_fall: assert property ($fell(phy_irq_o) |->
        $past(mgmt_rd_i, 2) || $past(mgmt_wr_i, 2)) else $error("irq dropped early");
endmodule : perc_phy_event_ctrl_asserts

bind perc_phy_event_ctrl perc_phy_event_ctrl_asserts perc_phy_event_ctrl_asserts_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .mgmt_wr_i(mgmt_wr_i), .mgmt_rd_i(mgmt_rd_i),
    .mgmt_rdata_o(mgmt_rdata_o), .mgmt_rvalid_o(mgmt_rvalid_o), .mode_100tx_i(mode_100tx_i),
    .loopback_select_i(loopback_select_i), .rx_active_i(rx_active_i), .link_ok_i(link_ok_i),
    .ev_i({jabber_i, rx_error_i, page_rx_i, parallel_fault_i, partner_ack_i, remote_fault_i,
        negotiation_done_i}), .coding_sublayer_bypass_o(coding_sublayer_bypass_o),
    .rx_clock_enable_o(rx_clock_enable_o), .phy_irq_o(phy_irq_o));

// File: bench/perc_host_model.sv
module perc_host_model
    import perc_pkg::*;
(
    // Clock
    input  wire logic        clk_i,
    // Requests
    output logic      [4:0]  mgmt_addr_o,
    output logic             mgmt_wr_o,
    output logic             mgmt_rd_o,
    output logic      [15:0] mgmt_wdata_o,
    // Answers
    input  wire logic [15:0] mgmt_rdata_i,
    input  wire logic        mgmt_rvalid_i
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        mgmt_addr_o  = 5'h00;
        mgmt_wr_o    = 1'b0;
        mgmt_rd_o    = 1'b0;
        mgmt_wdata_o = 16'h0000;
    end
    // Entered at a falling edge; a strobe lasts one cycle
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        mgmt_addr_o  = a;
        mgmt_wdata_o = d;
        mgmt_wr_o    = 1'b1;
        @(negedge clk_i);
        mgmt_wr_o    = 1'b0;
        // Released data never keeps its last value
        mgmt_wdata_o = ~d;
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic v);
        mgmt_addr_o = a;
        mgmt_rd_o   = 1'b1;
        @(negedge clk_i);
        mgmt_rd_o   = 1'b0;
        d = mgmt_rdata_i;
        v = mgmt_rvalid_i;
    endtask : rd
endmodule : perc_host_model

// File: bench/phy_event_interrupt_and_rx_control_bench.sv
module phy_event_interrupt_and_rx_control_bench
    import perc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i, resetn_i, wr, rd, rv, mode, an, lb, act, pw, rxd;
    logic        rxd_o, inv, byp, cken, irq;
    logic [4:0]  addr;
    logic [7:0]  ev;
    logic [15:0] wd, rdat;
    int          errors, tests_run;
    perc_host_model perc_host_model_inst (.clk_i(clk_i), .mgmt_addr_o(addr), .mgmt_wr_o(wr),
        .mgmt_rd_o(rd), .mgmt_wdata_o(wd), .mgmt_rdata_i(rdat), .mgmt_rvalid_i(rv));
    perc_phy_event_ctrl perc_phy_event_ctrl_inst (.clk_i(clk_i), .resetn_i(resetn_i),
        .mgmt_addr_i(addr), .mgmt_wr_i(wr), .mgmt_rd_i(rd), .mgmt_wdata_i(wd),
        .mgmt_rdata_o(rdat), .mgmt_rvalid_o(rv), .mode_100tx_i(mode), .autoneg_en_i(an),
        .loopback_select_i(lb), .rx_active_i(act), .polarity_wrong_i(pw), .rx_data_i(rxd),
        .link_ok_i(~ev[2]), .jabber_i(ev[7]), .rx_error_i(ev[6]), .page_rx_i(ev[5]),
        .parallel_fault_i(ev[4]), .partner_ack_i(ev[3]), .remote_fault_i(ev[1]),
        .negotiation_done_i(ev[0]), .rx_data_o(rxd_o), .rx_polarity_inverted_o(inv),
        .coding_sublayer_bypass_o(byp), .rx_clock_enable_o(cken), .phy_irq_o(irq));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask : tick
    task automatic rdc(input logic [4:0] a, input logic [15:0] e);
        logic [15:0] d;
        logic        v;
        perc_host_model_inst.rd(a, d, v);
        chk("rvalid", 16'h0001, {15'h0000, v});
        chk("rdata", e, d);
    endtask : rdc
    task automatic t_reset;
        chk("clken", 16'h0001, {15'h0000, cken});
        chk("irq", 16'h0000, {15'h0000, irq});
        rdc(PERC_ADDR_EVENT, 16'h0000);
        tick(1);
        rdc(5'h05, 16'h0000);
        tick(1);
        rdc(PERC_ADDR_RXCTL, 16'h0000);
        $display("reset test done");
    endtask : t_reset
    task automatic t_events;
        perc_host_model_inst.wr(PERC_ADDR_EVENT, 16'hff00);
        for (int i = 0; i < PERC_EVT_COUNT; i++) begin
            ev = 8'h01 << i;
            tick(1);
            ev = 8'h00;
            tick(2);
            chk("irq", 16'h0001, {15'h0000, irq});
            rdc(PERC_ADDR_EVENT, 16'hff00 | (16'h0001 << i));
            tick(2);
            chk("irq", 16'h0000, {15'h0000, irq});
            rdc(PERC_ADDR_EVENT, 16'hff00);
        end
        $display("event test done");
    endtask : t_events
    task automatic t_mask;
        perc_host_model_inst.wr(PERC_ADDR_EVENT, 16'h00ff);
        ev = 8'h80;
        tick(1);
        ev = 8'h00;
        tick(3);
        chk("irq", 16'h0000, {15'h0000, irq});
        ev = 8'h40;
        rdc(PERC_ADDR_EVENT, 16'h0080);
        ev = 8'h00;
        tick(1);
        rdc(PERC_ADDR_EVENT, 16'h0040);
        $display("mask test done");
    endtask : t_mask
    task automatic t_pol;
        an = 1'b1;
        pw = 1'b1;
        tick(3);
        chk("inv", 16'h0001, {15'h0000, inv});
        chk("rxd", 16'h0000, {15'h0000, rxd_o});
        perc_host_model_inst.wr(PERC_ADDR_RXCTL, 16'h0000);
        rdc(PERC_ADDR_RXCTL, 16'h0010);
        perc_host_model_inst.wr(PERC_ADDR_RXCTL, 16'h0020);
        tick(2);
        chk("inv", 16'h0000, {15'h0000, inv});
        perc_host_model_inst.wr(PERC_ADDR_RXCTL, 16'h0030);
        tick(2);
        chk("rxd", 16'h0000, {15'h0000, rxd_o});
        rdc(PERC_ADDR_RXCTL, 16'h0030);
        rxd = 1'b0;
        tick(2);
        chk("rxd", 16'h0001, {15'h0000, rxd_o});
        rxd = 1'b1;
        perc_host_model_inst.wr(PERC_ADDR_RXCTL, 16'h0020);
        tick(2);
        chk("rxd", 16'h0001, {15'h0000, rxd_o});
        $display("polarity test done");
    endtask : t_pol
    task automatic t_rxc;
        an = 1'b0;
        mode = 1'b1;
        perc_host_model_inst.wr(PERC_ADDR_RXCTL, 16'h0022);
        tick(2);
        chk("bypass", 16'h0001, {15'h0000, byp});
        mode = 1'b0;
        tick(2);
        chk("bypass", 16'h0000, {15'h0000, byp});
        mode = 1'b1;
        // Gating only once bypass is off
        perc_host_model_inst.wr(PERC_ADDR_RXCTL, 16'h0021);
        tick(2);
        chk("clken", 16'h0000, {15'h0000, cken});
        act = 1'b1;
        tick(2);
        chk("clken", 16'h0001, {15'h0000, cken});
        act = 1'b0;
        lb = 1'b1;
        tick(2);
        chk("clken", 16'h0001, {15'h0000, cken});
        $display("receive control test done");
    endtask : t_rxc
    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        {resetn_i, mode, an, lb, act, pw} = 6'h00;
        rxd = 1'b1;
        ev = 8'h00;
        errors = 0;
        tests_run = 0;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        resetn_i = 1'b1;
        t_reset;
        t_events;
        t_mask;
        t_pol;
        t_rxc;
        results;
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        errors++;
        results;
    end
endmodule : phy_event_interrupt_and_rx_control_bench
